// [src/fpl_pkg.sv]
`default_nettype none
package fpl_pkg;
  // Register byte offsets
  localparam logic [7:0] FPL_CTRL_OFF = 8'h00;
  localparam logic [7:0] FPL_STAT_OFF = 8'h04;
  localparam logic [7:0] FPL_DISP_OFF = 8'h08;
  localparam logic [7:0] FPL_FIFO_OFF = 8'h0C;
  // Control field positions
  localparam int FPL_CTRL_LOAD_BIT = 0;
  localparam int FPL_CTRL_SCAN_DIS_BIT = 1;
  // Reset values
  localparam logic [1:0] FPL_CTRL_RST = 2'h0;
  localparam logic [7:0] FPL_BYTE_RST = 8'h00;
  // Start address when the button is held entering run
  localparam logic [15:0] FPL_ALT_START = 16'h8000;
  localparam logic [15:0] FPL_ZERO_START = 16'h0000;
  // Byte buffer shape
  localparam int FPL_FIFO_W = 8;
  localparam int FPL_FIFO_D = 16;
  // Scan divider terminal count; the 10-bit counter gives one interrupt per 1024 cycles
  localparam logic [9:0] FPL_SCAN_DIV = 10'h3FF;

  // Processor bus levels kept as one group, each bit filtered on its own
  typedef struct packed {
    logic dma_cycle;
    logic read_n;
    logic write_n;
    logic timing_pulse_b;
  } fpl_bus_s;

  // Request FSM
  typedef enum logic [1:0] {
    FPL_IDLE = 2'b00,
    FPL_PRESSED = 2'b01,
    FPL_REQ = 2'b10,
    FPL_WAIT_RB = 2'b11
  } fpl_req_e;
endpackage : fpl_pkg
`default_nettype wire

// [src/fpl_fifo.sv]
`default_nettype none
module fpl_fifo
  import fpl_pkg::*;
#(
  parameter int WIDTH = FPL_FIFO_W,
  parameter int DEPTH = FPL_FIFO_D
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  // Storage words
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // Full compare at the wider count width; DEPTH does not fit AW bits
  assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign o_out_data = mem_reg[rd_ptr_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // Word store, no reset needed on data
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      // Simultaneous push and pop keeps level
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : fpl_fifo
`default_nettype wire

// [src/fpl_top.sv]
// Function
// (R1) Press drives flag low, holds request clear
// (R2) Release raises flag, sets DMA-in request
// (R3) Processor runs DMA write cycle in answer
// (R4) Switch buffer drives bus during load writes
// (R5) State code bit one resets request
// (R6) Read-back low arms latch at pulse B
// (R7) Processor clock runs only with run high
// (R8) All-ones bus makes processor step reads
// (R9) Forced no-op runs from every address
// (R10) Display shows output port four value
// (R11) Button held entering run starts 8000h
// (R12) Option disables display scan interrupts
// (R13) Processor finishes instruction, uses register zero
// (R14) One request per press and release
//
// Register access over Wishbone and the register offsets were chosen for this implementation.
`default_nettype none
module fpl_top
  import fpl_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Panel pins
  input wire logic i_load_button_n,
  input wire logic [7:0] i_data_switches,
  input wire logic i_run,
  // Processor bus pins
  input wire logic i_state_code_bit1,
  input wire logic i_timing_pulse_b,
  input wire logic i_mem_read_strobe_n,
  input wire logic i_mem_write_strobe_n,
  input wire logic [7:0] i_data_bus_lines,
  input wire logic [7:0] i_output_port_four,
  output logic [7:0] o_data_bus_lines,
  output logic o_data_bus_lines_oe,
  output logic o_panel_button_flag,
  output logic o_dma_in_n,
  output logic o_start_8000,
  output logic [7:0] o_display_latch,
  output logic [7:0] o_hex_display,
  output logic o_scan_irq
);
  // Three-stage synchronisers for pins
  logic [2:0] btn_sync_reg;
  logic [2:0] sc1_sync_reg;
  logic [2:0] tpb_sync_reg;
  logic [2:0] rd_sync_reg;
  logic [2:0] wr_sync_reg;
  logic [2:0] run_sync_reg;
  // Byte-wide pins, three stages each
  logic [7:0] sw_sync_reg [3];
  logic [7:0] dbus_sync_reg [3];
  logic [7:0] port4_sync_reg [3];
  // Settled bytes, taken when stages two and three agree
  logic [7:0] sw_reg;
  logic [7:0] dbus_reg;
  logic [7:0] port4_reg;
  // Filtered levels, update when stages two and three agree
  logic btn_n_reg;
  fpl_bus_s bus_reg;
  fpl_bus_s bus_prev_reg;
  logic run_reg;
  logic run_prev_reg;
  // Request state
  fpl_req_e req_state_reg;
  // Display arming and latch
  logic disp_armed_reg;
  logic [7:0] disp_byte_reg;
  // Control register
  logic [1:0] ctrl_reg;
  // Scan divider
  logic [9:0] scan_cnt_reg;
  // Captured bytes buffer
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic fifo_pop;
  logic cap_valid_reg;
  logic [7:0] cap_byte_reg;
  // Wishbone decode
  logic wb_req;
  logic [31:0] rd_word;

  // Pin synchronisers
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      btn_sync_reg <= 3'h7;
      sc1_sync_reg <= 3'h0;
      tpb_sync_reg <= 3'h0;
      rd_sync_reg <= 3'h7;
      wr_sync_reg <= 3'h7;
      run_sync_reg <= 3'h0;
    end else begin
      btn_sync_reg <= {btn_sync_reg[1:0], i_load_button_n};
      sc1_sync_reg <= {sc1_sync_reg[1:0], i_state_code_bit1};
      tpb_sync_reg <= {tpb_sync_reg[1:0], i_timing_pulse_b};
      rd_sync_reg <= {rd_sync_reg[1:0], i_mem_read_strobe_n};
      wr_sync_reg <= {wr_sync_reg[1:0], i_mem_write_strobe_n};
      run_sync_reg <= {run_sync_reg[1:0], i_run};
    end
  end

  // Byte synchronisers; a word is taken only when the last two
  // stages agree, so bits that change with some skew never land
  // as a half-old, half-new byte
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      sw_sync_reg <= '{default: FPL_BYTE_RST};
      dbus_sync_reg <= '{default: FPL_BYTE_RST};
      port4_sync_reg <= '{default: FPL_BYTE_RST};
      sw_reg <= FPL_BYTE_RST;
      dbus_reg <= FPL_BYTE_RST;
      port4_reg <= FPL_BYTE_RST;
    end else begin
      sw_sync_reg <= '{i_data_switches, sw_sync_reg[0], sw_sync_reg[1]};
      dbus_sync_reg <= '{i_data_bus_lines, dbus_sync_reg[0],
                         dbus_sync_reg[1]};
      port4_sync_reg <= '{i_output_port_four, port4_sync_reg[0],
                          port4_sync_reg[1]};
      if (sw_sync_reg[2] == sw_sync_reg[1]) begin
        sw_reg <= sw_sync_reg[2];
      end
      if (dbus_sync_reg[2] == dbus_sync_reg[1]) begin
        dbus_reg <= dbus_sync_reg[2];
      end
      if (port4_sync_reg[2] == port4_sync_reg[1]) begin
        port4_reg <= port4_sync_reg[2];
      end
    end
  end

  // Filtered levels follow once two stages agree
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      btn_n_reg <= 1'b1;
      bus_reg <= '{dma_cycle: 1'b0, read_n: 1'b1, write_n: 1'b1,
                   timing_pulse_b: 1'b0};
      bus_prev_reg <= '{dma_cycle: 1'b0, read_n: 1'b1, write_n: 1'b1,
                        timing_pulse_b: 1'b0};
      run_reg <= 1'b0;
      run_prev_reg <= 1'b0;
    end else begin
      if (btn_sync_reg[2] == btn_sync_reg[1]) begin
        btn_n_reg <= btn_sync_reg[2];
      end
      if (sc1_sync_reg[2] == sc1_sync_reg[1]) begin
        bus_reg.dma_cycle <= sc1_sync_reg[2];
      end
      if (rd_sync_reg[2] == rd_sync_reg[1]) begin
        bus_reg.read_n <= rd_sync_reg[2];
      end
      if (wr_sync_reg[2] == wr_sync_reg[1]) begin
        bus_reg.write_n <= wr_sync_reg[2];
      end
      if (tpb_sync_reg[2] == tpb_sync_reg[1]) begin
        bus_reg.timing_pulse_b <= tpb_sync_reg[2];
      end
      if (run_sync_reg[2] == run_sync_reg[1]) begin
        run_reg <= run_sync_reg[2];
      end
      bus_prev_reg <= bus_reg;
      run_prev_reg <= run_reg;
    end
  end

  // Button flag mirrors the debounced button
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_panel_button_flag <= 1'b1;
    end else begin
      // (R1) Flag low while pressed
      o_panel_button_flag <= btn_n_reg;
    end
  end

  // Request sequencer, one request per press
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      req_state_reg <= FPL_IDLE;
      o_dma_in_n <= 1'b1;
    end else begin
      unique case (req_state_reg)
        FPL_IDLE: begin
          // (R1) Press holds request cleared
          if (!btn_n_reg) begin
            req_state_reg <= FPL_PRESSED;
          end
          o_dma_in_n <= 1'b1;
        end
        FPL_PRESSED: begin
          // (R2) Release sets request
          if (btn_n_reg) begin
            req_state_reg <= FPL_REQ;
            o_dma_in_n <= 1'b0;
          end
        end
        FPL_REQ: begin
          // (R5) DMA state code clears request
          if (bus_reg.dma_cycle) begin
            req_state_reg <= FPL_WAIT_RB;
            o_dma_in_n <= 1'b1;
          end else if (!btn_n_reg) begin
            // (R1) Repress clears a pending request
            req_state_reg <= FPL_PRESSED;
            o_dma_in_n <= 1'b1;
          end
        end
        FPL_WAIT_RB: begin
          // (R14) No rearm until state code drops
          if (!bus_reg.dma_cycle) begin
            req_state_reg <= FPL_IDLE;
          end
        end
      endcase
    end
  end

  // Switch buffer drive, in load mode whenever the read strobe is high
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_data_bus_lines <= FPL_BYTE_RST;
      o_data_bus_lines_oe <= 1'b0;
    end else begin
      // (R4) Read high and load mode enables buffer
      o_data_bus_lines <= sw_reg;
      o_data_bus_lines_oe <= bus_reg.read_n &&
                             ctrl_reg[FPL_CTRL_LOAD_BIT];
    end
  end

  // Display latch armed by read, taken at pulse B rise
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      disp_armed_reg <= 1'b0;
      disp_byte_reg <= FPL_BYTE_RST;
    end else begin
      // (R6) Read low arms the latch
      disp_armed_reg <= !bus_reg.read_n;
      if (disp_armed_reg && bus_reg.timing_pulse_b && !bus_prev_reg.timing_pulse_b) begin
        // (R6) Latch read-back byte on pulse B
        disp_byte_reg <= dbus_reg;
      end
    end
  end

  // Capture each byte stored in load mode into the buffer
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cap_valid_reg <= 1'b0;
      cap_byte_reg <= FPL_BYTE_RST;
    end else begin
      // Write strobe rising ends a DMA store
      if (bus_reg.write_n && !bus_prev_reg.write_n &&
          bus_prev_reg.dma_cycle && o_data_bus_lines_oe) begin
        cap_valid_reg <= 1'b1;
        cap_byte_reg <= o_data_bus_lines;
      end else if (fifo_in_ready) begin
        // A full buffer stalls; byte is dropped by next capture only
        cap_valid_reg <= 1'b0;
      end
    end
  end

  fpl_fifo #(
    .WIDTH(FPL_FIFO_W),
    .DEPTH(FPL_FIFO_D)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_in_valid(cap_valid_reg),
    .i_in_data(cap_byte_reg),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(fifo_out_valid),
    .o_out_data(fifo_out_data),
    .i_out_ready(fifo_pop)
  );

  // Panel outputs and start address strap
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_display_latch <= FPL_BYTE_RST;
      o_hex_display <= FPL_BYTE_RST;
      o_start_8000 <= 1'b0;
    end else begin
      o_display_latch <= disp_byte_reg;
      // (R10) Hex display follows port four
      o_hex_display <= port4_reg;
      // (R11) Button held at clear to run
      if (run_reg && !run_prev_reg) begin
        o_start_8000 <= (btn_n_reg == 1'b0);
      end
    end
  end

  // Scan divider; interrupt blocked by option bit
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      scan_cnt_reg <= '0;
      o_scan_irq <= 1'b0;
    end else begin
      scan_cnt_reg <= scan_cnt_reg + 10'h001;
      // (R12) Option masks scan interrupts
      o_scan_irq <= (scan_cnt_reg == FPL_SCAN_DIV) &&
                    !ctrl_reg[FPL_CTRL_SCAN_DIS_BIT];
    end
  end

  // Wishbone classic: ack one cycle after request
  assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign fifo_pop = wb_req && !i_wb_we && (i_wb_adr == FPL_FIFO_OFF);

  // Read mux; unmapped reads zero
  always_comb begin
    rd_word = 32'h00000000;
    unique case (i_wb_adr)
      FPL_CTRL_OFF: rd_word = {30'h00000000, ctrl_reg};
      FPL_STAT_OFF: rd_word = {24'h000000, o_start_8000, fifo_out_valid,
                               !fifo_in_ready, o_dma_in_n,
                               o_panel_button_flag, req_state_reg,
                               disp_armed_reg};
      FPL_DISP_OFF: rd_word = {24'h000000, disp_byte_reg};
      FPL_FIFO_OFF: rd_word = {23'h000000, fifo_out_valid, fifo_out_data};
      default: rd_word = 32'h00000000;
    endcase
  end

  // Bus answer
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else begin
      o_wb_ack <= wb_req;
      o_wb_dat <= wb_req ? rd_word : 32'h00000000;
    end
  end

  // Control register write, low byte lane
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      ctrl_reg <= FPL_CTRL_RST;
    end else if (wb_req && i_wb_we && i_wb_sel[0] &&
                 i_wb_adr == FPL_CTRL_OFF) begin
      ctrl_reg <= i_wb_dat[1:0];
    end
  end
endmodule : fpl_top
`default_nettype wire

// [tb/fpl_checker.sv]
`default_nettype none
module fpl_checker (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Bus side
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  // Panel and processor pins
  input wire logic i_load_button_n,
  input wire logic i_state_code_bit1,
  input wire logic i_mem_read_strobe_n,
  input wire logic [7:0] i_output_port_four,
  input wire logic o_data_bus_lines_oe,
  input wire logic o_panel_button_flag,
  input wire logic o_dma_in_n,
  input wire logic [7:0] o_hex_display,
  input wire logic o_scan_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // One domain, so clock and reset are given once
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  ack_next_a: assert property (
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("ack not one cycle after request");
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held");
  dat_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h00000000)
    else $error("read data outside ack");
  flag_low_a: assert property (
    !i_load_button_n [*8] |-> !o_panel_button_flag)
    else $error("flag high while pressed");
  press_clear_a: assert property (
    !i_load_button_n [*8] |-> o_dma_in_n)
    else $error("request while pressed");
  flag_high_a: assert property (
    i_load_button_n [*8] |-> o_panel_button_flag)
    else $error("flag low while released");
  req_reset_a: assert property (
    i_state_code_bit1 [*8] |-> o_dma_in_n)
    else $error("request survives state code");
  req_once_a: assert property (
    $fell(o_dma_in_n) |-> i_load_button_n && !i_state_code_bit1)
    else $error("request without release");
  bus_free_a: assert property (
    !i_mem_read_strobe_n [*8] |-> !o_data_bus_lines_oe)
    else $error("switches drive during read");
  hex_show_a: assert property (
    $stable(i_output_port_four) [*8] |->
    o_hex_display == i_output_port_four)
    else $error("hex display differs");
  irq_pulse_a: assert property (
    o_scan_irq |=> !o_scan_irq)
    else $error("scan irq held");
  // Main scenarios seen
  cover property ($fell(o_dma_in_n));
  cover property (o_scan_irq);
  cover property (o_wb_ack && o_wb_dat != 32'h00000000);
endmodule : fpl_checker
bind fpl_top fpl_checker u_chk (.*);
`default_nettype wire

// [tb/fpl_cpu_model.sv]
`default_nettype none
module fpl_cpu_model #(
  parameter int DLY = 3 // Cycles spent finishing an instruction
) (
  // Clock and run level
  input wire logic i_sys_clk,
  input wire logic i_run,
  // Panel side
  input wire logic i_dma_in_n,
  input wire logic [7:0] i_bus,
  input wire logic i_bus_oe,
  // Processor bus
  output logic o_sc1,
  output logic o_tpb,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic [7:0] o_bus,
  // Observation
  output logic [7:0] o_count,
  output logic [7:0] o_last
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [16]; // Memory behind register zero
  logic [3:0] r0; // Transfer address
  logic [7:0] drv; // Processor copy, memory byte at read-back, all ones when released
  // Panel buffer wins the wire while enabled
  assign o_bus = i_bus_oe ? i_bus : drv;
  task automatic step(input int n);
    repeat (n) begin
      @(posedge i_sys_clk);
      // processor clock stops while run is low
      while (i_run !== 1'b1) @(posedge i_sys_clk);
    end
  endtask : step
  // One DMA-in transfer per request seen
  initial begin
    o_sc1 = 1'b0;
    o_tpb = 1'b0;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_count = 8'h00;
    o_last = 8'h00;
    r0 = 4'h0;
    // released bus rests high on its pull-ups
    drv = 8'hFF;
    forever begin
      @(posedge i_sys_clk);
      if (i_dma_in_n === 1'b0 && i_run === 1'b1) begin
        step(DLY);
        o_sc1 <= 1'b1;
        o_wr_n <= 1'b0;
        step(8);
        mem[r0] = o_bus;
        o_last <= o_bus;
        o_wr_n <= 1'b1;
        o_sc1 <= 1'b0;
        step(2);
        o_rd_n <= 1'b0;
        drv <= mem[r0];
        step(6);
        o_tpb <= 1'b1;
        step(6);
        o_tpb <= 1'b0;
        o_rd_n <= 1'b1;
        // bus released back to the pull-up level
        drv <= 8'hFF;
        r0 <= r0 + 4'h1;
        o_count <= o_count + 8'h01;
        step(10);
      end
    end
  end
endmodule : fpl_cpu_model
`default_nettype wire

// [tb/tb_top.sv]
`default_nettype none
module tb_top
  import fpl_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk, i_reset, i_wb_cyc, i_wb_stb, i_wb_we, i_run;
  logic i_load_button_n, i_state_code_bit1, i_timing_pulse_b;
  logic i_mem_read_strobe_n, i_mem_write_strobe_n;
  logic [7:0] i_wb_adr, i_data_switches, i_data_bus_lines;
  logic [7:0] i_output_port_four, o_data_bus_lines, o_display_latch;
  logic [7:0] o_hex_display, cnt, last;
  logic [3:0] i_wb_sel;
  logic [31:0] i_wb_dat, o_wb_dat, q;
  logic o_wb_ack, o_data_bus_lines_oe, o_panel_button_flag;
  logic o_dma_in_n, o_start_8000, o_scan_irq;
  int err_count, total_checks, n, irqs;
  fpl_top DUT (.*);
  fpl_cpu_model #(.DLY(3)) CPU (.i_sys_clk(i_sys_clk), .i_run(i_run),
    .i_dma_in_n(o_dma_in_n), .i_bus(o_data_bus_lines),
    .i_bus_oe(o_data_bus_lines_oe), .o_sc1(i_state_code_bit1),
    .o_tpb(i_timing_pulse_b), .o_rd_n(i_mem_read_strobe_n),
    .o_wr_n(i_mem_write_strobe_n), .o_bus(i_data_bus_lines),
    .o_count(cnt), .o_last(last));
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge i_sys_clk);
  endtask : tick
  // Classic single Wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_adr <= a;
    i_wb_dat <= d;
    @(posedge i_sys_clk);
    while (o_wb_ack !== 1'b1) @(posedge i_sys_clk);
    q = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask : wb
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Press, release, then wait for the transfer to end
  task automatic load(input logic [7:0] v);
    i_data_switches <= v;
    i_load_button_n <= 1'b0;
    tick(10);
    chk("flag pressed", 0, o_panel_button_flag);
    chk("no request pressed", 1, o_dma_in_n);
    i_load_button_n <= 1'b1;
    tick(10);
    chk("flag released", 1, o_panel_button_flag);
    for (int k = 0; k < 300 && cnt === n[7:0]; k++) tick(1);
    n++;
    tick(12);
    chk("stored byte", v, last);
    chk("transfers", n, cnt);
    chk("latch", v, o_display_latch);
    chk("request idle", 1, o_dma_in_n);
  endtask : load
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  // Watchdog well beyond the expected run
  initial begin
    tick(30000);
    err_count++;
    finish_test;
  end
  initial begin
    i_reset = 1'b1;
    i_wb_cyc = 1'b0;
    i_wb_stb = 1'b0;
    i_wb_we = 1'b0;
    i_wb_adr = 8'h00;
    i_wb_dat = 32'h0;
    i_wb_sel = 4'hF;
    i_run = 1'b0;
    i_load_button_n = 1'b1;
    i_data_switches = 8'h00;
    i_output_port_four = 8'h00;
    err_count = 0;
    total_checks = 0;
    n = 0;
    tick(12);
    i_reset <= 1'b0;
    tick(2);
    chk("oe reset", 0, o_data_bus_lines_oe);
    wb(1'b0, FPL_CTRL_OFF, 32'h0);
    chk("ctrl reset", FPL_CTRL_RST, q);
    wb(1'b1, 8'h40, 32'hFF);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 0, q);
    i_run <= 1'b1;
    tick(10);
    chk("plain start", 0, o_start_8000);
    $display("test reset done");
    // Load mode, scan masked; fill the buffer
    wb(1'b1, FPL_CTRL_OFF, 32'h3);
    for (int k = 0; k < 16; k++) load({k[3:0], k[3:0]});
    wb(1'b0, FPL_STAT_OFF, 32'h0);
    chk("fifo full", 1, q[5]);
    wb(1'b0, FPL_DISP_OFF, 32'h0);
    chk("display reg", 8'hFF, q);
    for (int k = 0; k < 16; k++) begin
      wb(1'b0, FPL_FIFO_OFF, 32'h0);
      chk("fifo pop", {24'h1, k[3:0], k[3:0]}, q);
    end
    wb(1'b0, FPL_FIFO_OFF, 32'h0);
    chk("fifo empty", 0, q[8]);
    $display("test load done");
    i_output_port_four <= 8'h3C;
    tick(10);
    chk("hex", 8'h3C, o_hex_display);
    // Masked, then one per scan period
    irqs = 0;
    repeat (1100) begin
      tick(1);
      irqs += (o_scan_irq === 1'b1);
    end
    chk("irq masked", 0, irqs);
    wb(1'b1, FPL_CTRL_OFF, 32'h1);
    irqs = 0;
    repeat (1024) begin
      tick(1);
      irqs += (o_scan_irq === 1'b1);
    end
    chk("irq count", 1, irqs);
    $display("test scan done");
    // Button held while entering run
    i_run <= 1'b0;
    i_load_button_n <= 1'b0;
    tick(10);
    i_run <= 1'b1;
    tick(10);
    chk("alt start", 1, o_start_8000);
    i_load_button_n <= 1'b1;
    tick(60);
    $display("test strap done");
    finish_test;
  end
endmodule : tb_top
`default_nettype wire
